// ===== pkg/imu_power_pkg.sv
// Shared constants and types for the inertial power-mode and rate control block.
package imu_power_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ACCEL_CONTROL_REG_ADDR = 8'h10;
  localparam logic [7:0] GYRO_CONTROL_REG_ADDR = 8'h11;
  localparam logic [7:0] COMMON_CONTROL_REG_ADDR = 8'h13;
  localparam logic [7:0] ACCEL_MODE_REG_ADDR = 8'h15;
  localparam logic [7:0] GYRO_MODE_REG_ADDR = 8'h16;
  localparam logic [7:0] STATUS_REG_ADDR = 8'h1E;
  localparam logic [7:0] ACCEL_DATA_ADDR = 8'h28;
  localparam logic [7:0] GYRO_DATA_ADDR = 8'h22;

  // Field positions.
  localparam int RATE_SEL_LSB = 4;
  localparam int HIPERF_DISABLE_BIT = 4;
  localparam int GYRO_SLEEP_BIT = 6;
  localparam int STAT_BOOT_BIT = 7;

  // Reset values.
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Rate codes.
  localparam logic [3:0] RATE_OFF = 4'h0;
  localparam logic [3:0] RATE_1P6 = 4'hB;
  localparam logic [3:0] RATE_NORMAL_LO = 4'h4;
  localparam logic [3:0] RATE_NORMAL_HI = 4'h5;
  localparam logic [3:0] RATE_HP_ONLY_LO = 4'h6;
  localparam logic [3:0] RATE_MAX = 4'hA;

  // Timing.
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int BOOT_TIME_US = 10_000;
  localparam int BOOT_CYCLES = (CLK_FREQ_HZ / 1_000_000) * BOOT_TIME_US;
  // Base tick is 6.66 kHz, about 0.15 ns error per tick ignored.
  localparam int BASE_RATE_HZ = 6_660;
  localparam int BASE_TICK_CYCLES = CLK_FREQ_HZ / BASE_RATE_HZ;
  // Ticks of the base rate per 1.6 Hz sample.
  localparam int SLOW_DIV = 4096;

  typedef enum logic [4:0] {
    MODE_OFF = 5'b00001,
    MODE_LOW = 5'b00010,
    MODE_NORMAL = 5'b00100,
    MODE_HIGH = 5'b01000,
    MODE_SLEEP = 5'b10000
  } power_mode_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

endpackage

// ===== verilog/imu_power_ctrl.sv
// Power-mode and output-rate control for the accelerometer and gyroscope pair.
// Function
// - Boot loads trimming and completes in no more than 10 ms.
// - After boot both sensors are in power-down without host action.
// - Accel only, gyro only, or both running are all supported.
// - Accel rate and disable bit set mode; 0000 off; 1011 low-power only if disabled.
// - Disable set: 0001-0011 low-power, 0100-0101 normal for the accelerometer.
// - Disable clear gives high-performance for 0001-0101; 0110-1010 always high-performance.
// - Gyro rate and disable bit set mode; 0000 off; no 1.6 Hz.
// - Gyro disable set: low, normal, high bands; clear: all high-performance.
// - Both sensors are programmed independently with any rates.
// - With both running, samples of the slower sensor align to the faster sensor's sample grid.
// - Gyro sleep state exists, distinct from power-down.
// - Registers stay readable and writable while a sensor is powered down.
// - Power-down entry or exit never changes configuration registers.
// - In power-down the data registers hold the last sample.
// - High-performance samples arrive every 2^(10-n) base ticks, the 6.66 kHz base halved, so only near the selected rate.
// - High-performance keeps data-ready signalling enabled.
// - Sleep bit puts a running gyro to sleep regardless of rate code.
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
module imu_power_ctrl #(
  parameter int BOOT_CYCLES = imu_power_pkg::BOOT_CYCLES,
  parameter int SLOW_DIV = imu_power_pkg::SLOW_DIV
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire imu_power_pkg::reg_req_s req,
  input wire logic [7:0] accel_sample,
  input wire logic [7:0] gyro_sample,
  output logic [7:0] rdata,
  output logic boot_done,
  output logic [4:0] accel_mode,
  output logic [4:0] gyro_mode,
  output logic accel_drdy,
  output logic gyro_drdy
);

  localparam int TICK_CYCLES = imu_power_pkg::BASE_TICK_CYCLES;

  // Register file. Nothing here is ever touched by mode changes.
  logic [7:0] accel_control_reg;
  logic [7:0] gyro_control_reg;
  logic [7:0] common_control_reg;
  logic [7:0] accel_mode_reg;
  logic [7:0] gyro_mode_reg;
  logic [7:0] accel_data;
  logic [7:0] gyro_data;
  logic [23:0] boot_count;
  logic [11:0] tick_count;
  logic [11:0] base_index;
  logic base_tick;
  logic [7:0] next_rdata;

  wire logic wr_accel_ctl = req.wr && req.addr == imu_power_pkg::ACCEL_CONTROL_REG_ADDR;
  wire logic wr_gyro_ctl = req.wr && req.addr == imu_power_pkg::GYRO_CONTROL_REG_ADDR;
  wire logic wr_common = req.wr && req.addr == imu_power_pkg::COMMON_CONTROL_REG_ADDR;
  wire logic wr_accel_mode = req.wr && req.addr == imu_power_pkg::ACCEL_MODE_REG_ADDR;
  wire logic wr_gyro_mode = req.wr && req.addr == imu_power_pkg::GYRO_MODE_REG_ADDR;

  wire logic [3:0] accel_rate_sel = accel_control_reg[imu_power_pkg::RATE_SEL_LSB +: 4];
  wire logic [3:0] gyro_rate_sel = gyro_control_reg[imu_power_pkg::RATE_SEL_LSB +: 4];
  wire logic accel_hiperf_disable = accel_mode_reg[imu_power_pkg::HIPERF_DISABLE_BIT];
  wire logic gyro_hiperf_disable = gyro_mode_reg[imu_power_pkg::HIPERF_DISABLE_BIT];
  wire logic gyro_sleep_en = common_control_reg[imu_power_pkg::GYRO_SLEEP_BIT];

  // Mode decode, one function shared by both sensors.
  function automatic logic [4:0] decode_mode(input logic [3:0] code, input logic dis,
                                             input logic has_slow);
    logic [4:0] m;
    m = imu_power_pkg::MODE_OFF;
    if (code == imu_power_pkg::RATE_1P6)
    begin
      m = (has_slow && dis) ? imu_power_pkg::MODE_LOW : imu_power_pkg::MODE_OFF;
    end
    else if (code == imu_power_pkg::RATE_OFF || code > imu_power_pkg::RATE_MAX)
    begin
      m = imu_power_pkg::MODE_OFF;
    end
    else if (code >= imu_power_pkg::RATE_HP_ONLY_LO || !dis)
    begin
      m = imu_power_pkg::MODE_HIGH;
    end
    else if (code >= imu_power_pkg::RATE_NORMAL_LO)
    begin
      m = imu_power_pkg::MODE_NORMAL;
    end
    else
    begin
      m = imu_power_pkg::MODE_LOW;
    end
    return m;
  endfunction

  wire logic [4:0] accel_decoded = decode_mode(accel_rate_sel, accel_hiperf_disable, 1'b1);
  wire logic [4:0] gyro_raw = decode_mode(gyro_rate_sel, gyro_hiperf_disable, 1'b0);
  wire logic [4:0] gyro_decoded = (gyro_raw != imu_power_pkg::MODE_OFF && gyro_sleep_en)
                                  ? imu_power_pkg::MODE_SLEEP : gyro_raw;

  // Until boot finishes both sensors are forced off.
  wire logic [4:0] next_accel_mode = boot_done ? accel_decoded : imu_power_pkg::MODE_OFF;
  wire logic [4:0] next_gyro_mode = boot_done ? gyro_decoded : imu_power_pkg::MODE_OFF;

  // Rate code n (1..10) samples every 2^(10-n) base ticks; 1.6 Hz every SLOW_DIV ticks.
  // All periods are powers of two on one shared base index, so the two sensors
  // stay phase aligned and their rates divide one another.
  // Rates are thus approximate: the base rate halved, not the usual round-number rates.
  function automatic logic sample_due(input logic [3:0] code, input logic [11:0] idx);
    logic [11:0] mask;
    mask = 12'h000;
    if (code == imu_power_pkg::RATE_1P6)
    begin
      mask = 12'(SLOW_DIV - 1);
    end
    else if (code >= 4'h1 && code <= imu_power_pkg::RATE_MAX)
    begin
      mask = 12'((1 << (4'hA - code)) - 1);
    end
    return (idx & mask) == 12'h000;
  endfunction

  wire logic accel_running = accel_mode != imu_power_pkg::MODE_OFF;
  wire logic gyro_running = gyro_mode != imu_power_pkg::MODE_OFF &&
                            gyro_mode != imu_power_pkg::MODE_SLEEP;
  wire logic accel_due = base_tick && accel_running &&
                         sample_due(accel_rate_sel, base_index);
  wire logic gyro_due = base_tick && gyro_running &&
                        sample_due(gyro_rate_sel, base_index);

  always_comb
  begin
    next_rdata = 8'h00;
    if (req.rd)
    begin
      unique case (req.addr)
        imu_power_pkg::ACCEL_CONTROL_REG_ADDR: next_rdata = accel_control_reg;
        imu_power_pkg::GYRO_CONTROL_REG_ADDR: next_rdata = gyro_control_reg;
        imu_power_pkg::COMMON_CONTROL_REG_ADDR: next_rdata = common_control_reg;
        imu_power_pkg::ACCEL_MODE_REG_ADDR: next_rdata = accel_mode_reg;
        imu_power_pkg::GYRO_MODE_REG_ADDR: next_rdata = gyro_mode_reg;
        imu_power_pkg::STATUS_REG_ADDR: next_rdata = {boot_done, 2'b00, gyro_mode};
        imu_power_pkg::ACCEL_DATA_ADDR: next_rdata = accel_data;
        imu_power_pkg::GYRO_DATA_ADDR: next_rdata = gyro_data;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // Boot counter; trimming load is modelled as the fixed wait.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      boot_count <= 24'h000000;
      boot_done <= 1'b0;
    end
    else if (!boot_done)
    begin
      boot_count <= boot_count + 24'h000001;
      boot_done <= boot_count == 24'(BOOT_CYCLES - 2);
    end
  end

  // Registers accept access at all times, independent of sensor mode.
  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      accel_control_reg <= imu_power_pkg::CONTROL_RESET;
      gyro_control_reg <= imu_power_pkg::CONTROL_RESET;
      common_control_reg <= imu_power_pkg::CONTROL_RESET;
      accel_mode_reg <= imu_power_pkg::CONTROL_RESET;
      gyro_mode_reg <= imu_power_pkg::CONTROL_RESET;
      rdata <= 8'h00;
    end
    else
    begin
      if (wr_accel_ctl) accel_control_reg <= req.wdata;
      if (wr_gyro_ctl) gyro_control_reg <= req.wdata;
      if (wr_common) common_control_reg <= req.wdata;
      if (wr_accel_mode) accel_mode_reg <= req.wdata;
      if (wr_gyro_mode) gyro_mode_reg <= req.wdata;
      rdata <= next_rdata;
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      accel_mode <= imu_power_pkg::MODE_OFF;
      gyro_mode <= imu_power_pkg::MODE_OFF;
      tick_count <= 12'h000;
      base_index <= 12'h000;
      base_tick <= 1'b0;
      accel_data <= 8'h00;
      gyro_data <= 8'h00;
      accel_drdy <= 1'b0;
      gyro_drdy <= 1'b0;
    end
    else
    begin
      accel_mode <= next_accel_mode;
      gyro_mode <= next_gyro_mode;
      base_tick <= tick_count == 12'(TICK_CYCLES - 1);
      tick_count <= (tick_count == 12'(TICK_CYCLES - 1)) ? 12'h000 : tick_count + 12'h001;
      if (base_tick) base_index <= base_index + 12'h001;
      // Data registers only move on a due sample, so power-down freezes them.
      if (accel_due) accel_data <= accel_sample;
      if (gyro_due) gyro_data <= gyro_sample;
      accel_drdy <= accel_due;
      gyro_drdy <= gyro_due;
    end
  end

  a_boot_forces_off: assert property (@(posedge core_clk) disable iff (reset)
    !boot_done |-> accel_mode == imu_power_pkg::MODE_OFF && gyro_mode == imu_power_pkg::MODE_OFF)
    else $error("sensor running before boot done");

  a_boot_bound: assert property (@(posedge core_clk) disable iff (reset)
    $rose(boot_done) |-> boot_count == 24'(BOOT_CYCLES - 1))
    else $error("boot length wrong");

  a_accel_hp_band: assert property (@(posedge core_clk) disable iff (reset)
    boot_done && accel_rate_sel >= 4'h6 && accel_rate_sel <= 4'hA
    |=> accel_mode == imu_power_pkg::MODE_HIGH || $changed(accel_rate_sel))
    else $error("accel high band not high performance");

  a_accel_slow_code: assert property (@(posedge core_clk) disable iff (reset)
    boot_done && accel_rate_sel == 4'hB && !accel_hiperf_disable
    |=> accel_mode == imu_power_pkg::MODE_OFF || $changed(accel_control_reg) ||
        $changed(accel_mode_reg))
    else $error("1.6 Hz allowed without disable bit");

  a_gyro_reserved_off: assert property (@(posedge core_clk) disable iff (reset)
    gyro_rate_sel > 4'hA |=> gyro_mode == imu_power_pkg::MODE_OFF || $changed(gyro_control_reg))
    else $error("gyro reserved code not off");

  a_gyro_sleep_wins: assert property (@(posedge core_clk) disable iff (reset)
    boot_done && gyro_sleep_en && gyro_raw != imu_power_pkg::MODE_OFF
    |=> gyro_mode == imu_power_pkg::MODE_SLEEP || $changed(common_control_reg) ||
        $changed(gyro_control_reg) || $changed(gyro_mode_reg))
    else $error("gyro sleep ignored");

  a_data_hold_off: assert property (@(posedge core_clk) disable iff (reset)
    accel_mode == imu_power_pkg::MODE_OFF |=> $stable(accel_data))
    else $error("accel data moved in power-down");

  // A lower code has the longer power-of-two period, so an accel sample at a code
  // not above the gyro code always falls on a gyro sample of the same tick.
  a_drdy_aligned: assert property (@(posedge core_clk) disable iff (reset)
    accel_drdy && $past(gyro_running) && $past(accel_rate_sel) <= $past(gyro_rate_sel)
    |-> gyro_drdy)
    else $error("gyro sample missing on aligned accel sample");

  a_config_kept: assert property (@(posedge core_clk) disable iff (reset)
    !wr_accel_ctl |=> $stable(accel_control_reg))
    else $error("config changed without write");

  a_gyro_config_kept: assert property (@(posedge core_clk) disable iff (reset)
    !wr_gyro_ctl |=> $stable(gyro_control_reg))
    else $error("gyro config changed without write");

  // The decoded mode lags its register by one clock, so each band check below
  // excuses a write that lands in the cycle it looks at.
  a_accel_off_code: assert property (@(posedge core_clk) disable iff (reset)
    boot_done && accel_rate_sel == 4'h0
    |=> accel_mode == imu_power_pkg::MODE_OFF || $changed(accel_control_reg))
    else $error("accel code zero not powered down");

  a_gyro_hp_band: assert property (@(posedge core_clk) disable iff (reset)
    boot_done && gyro_rate_sel >= 4'h6 && gyro_rate_sel <= 4'hA && !gyro_sleep_en
    |=> gyro_mode == imu_power_pkg::MODE_HIGH || $changed(gyro_control_reg) ||
        $changed(common_control_reg))
    else $error("gyro high band not high performance");

  // A powered-down or sleeping sensor must neither sample nor flag data, or a host
  // polling the data-ready line would read a stale value as new.
  a_accel_off_quiet: assert property (@(posedge core_clk) disable iff (reset)
    accel_mode == imu_power_pkg::MODE_OFF |=> !accel_drdy)
    else $error("accel data ready in power-down");

  a_gyro_data_hold: assert property (@(posedge core_clk) disable iff (reset)
    gyro_mode == imu_power_pkg::MODE_OFF || gyro_mode == imu_power_pkg::MODE_SLEEP
    |=> $stable(gyro_data))
    else $error("gyro data moved while stopped");

  a_sleep_no_sample: assert property (@(posedge core_clk) disable iff (reset)
    gyro_mode == imu_power_pkg::MODE_SLEEP |=> !gyro_drdy)
    else $error("gyro sampled while asleep");

  // Data ready and the captured value must come from the same edge, otherwise a
  // host reading on the ready pulse could get a value from another sample.
  a_accel_data_follows: assert property (@(posedge core_clk) disable iff (reset)
    accel_drdy |-> accel_data == $past(accel_sample))
    else $error("accel data not the sample taken");

  // Read data stand for one cycle only; an idle bus reads as zero, so a late
  // sample by the host shows up as zero rather than as a stale register.
  a_rdata_idle_zero: assert property (@(posedge core_clk) disable iff (reset)
    !$past(req.rd) |-> rdata == 8'h00)
    else $error("read data present without a read");

endmodule

// ===== dv/imu_host_model.sv
// Host processor model that drives the plain register port.
`timescale 1ns/1ps
module imu_host_model
(
  input wire logic core_clk,
  output imu_power_pkg::reg_req_s req,
  input wire logic [7:0] rdata
);
  initial req = '0;

  // A released bus drops both strobes and shows the inverse of its last address and data, so stale fields never look valid.
  task automatic release_bus();
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    req.addr <= ~req.addr;
    req.wdata <= ~req.wdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    release_bus();
  endtask

  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    req <= '{addr: a, wdata: req.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    release_bus();
    @(negedge core_clk);
    d = rdata;
  endtask
endmodule

// ===== dv/inertial_power_mode_rate_control_tb.sv
// Self-checking bench for the inertial power-mode and rate control block.
`timescale 1ns/1ps
module inertial_power_mode_rate_control_tb;
  localparam int BOOT = 20;
  localparam int TICK = imu_power_pkg::BASE_TICK_CYCLES;
  localparam logic [7:0] A_CTL = imu_power_pkg::ACCEL_CONTROL_REG_ADDR;
  localparam logic [7:0] G_CTL = imu_power_pkg::GYRO_CONTROL_REG_ADDR;
  localparam logic [7:0] C_CTL = imu_power_pkg::COMMON_CONTROL_REG_ADDR;
  localparam logic [7:0] A_MOD = imu_power_pkg::ACCEL_MODE_REG_ADDR;
  localparam logic [7:0] G_MOD = imu_power_pkg::GYRO_MODE_REG_ADDR;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] accel_sample = 8'h00;
  logic [7:0] gyro_sample = 8'h00;
  imu_power_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic boot_done;
  logic [4:0] accel_mode;
  logic [4:0] gyro_mode;
  logic accel_drdy;
  logic gyro_drdy;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int rel_cyc;
  int acc_q[$];
  int gyr_q[$];
  logic [7:0] mreg [0:255];
  logic [7:0] d;
  logic [7:0] s;
  logic [7:0] alist [6] = '{A_CTL, G_CTL, C_CTL, A_MOD, G_MOD, 8'h40};

  always #25 core_clk = ~core_clk;

  imu_power_ctrl #(.BOOT_CYCLES(BOOT), .SLOW_DIV(8)) i_dut (.core_clk(core_clk),
    .reset(reset), .req(req), .accel_sample(accel_sample), .gyro_sample(gyro_sample),
    .rdata(rdata), .boot_done(boot_done), .accel_mode(accel_mode), .gyro_mode(gyro_mode),
    .accel_drdy(accel_drdy), .gyro_drdy(gyro_drdy));

  imu_host_model i_host (.core_clk(core_clk), .req(req), .rdata(rdata));

  task automatic complete_run();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (accel_drdy === 1'b1) acc_q.push_back(cyc);
    if (gyro_drdy === 1'b1) gyr_q.push_back(cyc);
    if (cyc == 40000)
    begin
      fails++;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [4:0] exp_mode(int code, int dis, int gyro);
    if (code == 0 || code > 11) return imu_power_pkg::MODE_OFF;
    if (code == 11) return (gyro == 0 && dis == 1) ? imu_power_pkg::MODE_LOW
                                                   : imu_power_pkg::MODE_OFF;
    if (code >= 6 || dis == 0) return imu_power_pkg::MODE_HIGH;
    return (code <= 3) ? imu_power_pkg::MODE_LOW : imu_power_pkg::MODE_NORMAL;
  endfunction

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    i_host.wr(a, v);
    if (a inside {A_CTL, G_CTL, C_CTL, A_MOD, G_MOD}) mreg[a] = v;
  endtask

  task automatic rd_all();
    foreach (alist[i])
    begin
      i_host.rd(alist[i], d);
      check(d, mreg[alist[i]]);
    end
  endtask

  initial
  begin
    void'($urandom(32'h7BBB8598));
    foreach (mreg[i]) mreg[i] = 8'h00;
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    @(negedge core_clk);
    rel_cyc = cyc;
    check(boot_done, 1'b0);
    while (boot_done !== 1'b1 && cyc < rel_cyc + 200) @(negedge core_clk);
    check((cyc - rel_cyc >= BOOT - 1) && (cyc - rel_cyc <= BOOT + 1), 1);
    check(accel_mode, imu_power_pkg::MODE_OFF);
    check(gyro_mode, imu_power_pkg::MODE_OFF);
    rd_all();
    for (int dis = 0; dis < 2; dis++)
    begin
      wr_reg(A_MOD, 8'(dis * 16));
      wr_reg(G_MOD, 8'(dis * 16));
      for (int c = 0; c < 16; c++)
      begin
        wr_reg(A_CTL, {c[3:0], 4'h0});
        wr_reg(G_CTL, {4'(15 - c), 4'h0});
        repeat (3) @(negedge core_clk);
        check(accel_mode, exp_mode(c, dis, 0));
        check(gyro_mode, exp_mode(15 - c, dis, 1));
      end
    end
    wr_reg(G_CTL, 8'h40);
    wr_reg(C_CTL, 8'h40);
    repeat (3) @(negedge core_clk);
    check(gyro_mode, imu_power_pkg::MODE_SLEEP);
    wr_reg(G_CTL, 8'h00);
    repeat (3) @(negedge core_clk);
    check(gyro_mode, imu_power_pkg::MODE_OFF);
    wr_reg(C_CTL, 8'h00);
    wr_reg(A_MOD, 8'h00);
    wr_reg(G_MOD, 8'h00);
    s = 8'($urandom);
    @(posedge core_clk);
    accel_sample <= s;
    gyro_sample <= ~s;
    wr_reg(A_CTL, 8'hA0);
    wr_reg(G_CTL, 8'h90);
    @(negedge core_clk);
    acc_q.delete();
    gyr_q.delete();
    repeat (4 * TICK + 10) @(negedge core_clk);
    check(acc_q.size() >= 4 && gyr_q.size() >= 2, 1);
    for (int i = 1; i < acc_q.size(); i++) check(acc_q[i] - acc_q[i - 1], TICK);
    for (int i = 1; i < gyr_q.size(); i++) check(gyr_q[i] - gyr_q[i - 1], 2 * TICK);
    foreach (gyr_q[i]) check((gyr_q[i] - acc_q[0]) % TICK, 0);
    i_host.rd(imu_power_pkg::ACCEL_DATA_ADDR, d);
    check(d, s);
    i_host.rd(imu_power_pkg::GYRO_DATA_ADDR, d);
    check(d, 8'(~s));
    // Accelerometer goes down while the gyroscope keeps running.
    wr_reg(A_CTL, 8'h00);
    @(posedge core_clk);
    accel_sample <= s ^ (8'($urandom) | 8'h01);
    repeat (2) @(negedge core_clk);
    acc_q.delete();
    gyr_q.delete();
    repeat (2 * TICK + 10) @(negedge core_clk);
    check(acc_q.size(), 0);
    check(gyr_q.size() >= 1, 1);
    i_host.rd(imu_power_pkg::ACCEL_DATA_ADDR, d);
    check(d, s);
    rd_all();
    wr_reg(A_CTL, 8'h90);
    repeat (3) @(negedge core_clk);
    check(accel_mode, imu_power_pkg::MODE_HIGH);
    acc_q.delete();
    gyr_q.delete();
    repeat (2 * TICK + 10) @(negedge core_clk);
    check(acc_q.size() >= 1, 1);
    check(acc_q.size(), gyr_q.size());
    for (int i = 0; i < acc_q.size() && i < gyr_q.size(); i++) check(acc_q[i], gyr_q[i]);
    rd_all();
    complete_run();
  end
endmodule
